/* File: core/apd_diag_record.sv */
// Parameter store, output scaling and diagnostic record of the current module
// Function
// - Wire-break enable bits 0,1 per channel
// - Range FFh switches channel off
// - 31h: current is code times 20/27648 mA
// - 31h: overrange to 32511, limited at 0
// - 41h: current is code times 20/16384 mA
// - 41h: overrange to 20480, limited at 0
// - 30h: 4 mA plus code times 16/27648
// - 30h: up to 32511, down to -6912
// - 40h: 4 mA plus code times 16/16384
// - 40h: up to 20480, down to -4096
// - Errors light channel indicator and record
// - Record parameter errors, enabled wire-breaks only
// - Set 01h full record, 00h first four
// - Indices 2F01h, 2F00h and 5005h reach record
// - Record byte order with fixed descriptors
// - Error summary bits 2, 3 and 7
// - Module class 0101b with channel-info bit
// - Microsecond ticker from zero, stored at event
// - Group error bits per channel group
// - Channel byte: bit 0 config, bit 4 break
`timescale 1ns/10ps
module apd_diag_record #(
  parameter int NUM_CH = 2
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_srst,
  input  wire logic                     i_rec_wr,
  input  wire logic                     i_rec_rd,
  input  wire logic                     i_use_index,
  input  wire logic [7:0]               i_record_set_number,
  input  wire logic [15:0]              i_object_index,
  input  wire logic [7:0]               i_object_subindex,
  input  wire logic [4:0]               i_byte_offset,
  input  wire logic [7:0]               i_wdata,
  input  wire logic [NUM_CH-1:0][15:0]  i_out_code,
  input  wire logic [NUM_CH-1:0]        i_wire_break_pin,
  output logic      [7:0]               o_rdata,
  output logic                          o_rvalid,
  output logic                          o_rerr,
  output logic                          o_wack,
  output logic      [NUM_CH-1:0]        o_chan_active,
  output logic      [NUM_CH-1:0][14:0]  o_current_ua,
  output logic      [NUM_CH-1:0]        o_chan_err_led,
  output logic                          o_group_err_led
);

  // ----------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------
  logic [1:0]              wire_break_enable_r;
  logic [NUM_CH-1:0][7:0]  channel_range_select_r;
  logic [NUM_CH-1:0]       wsel_range;
  logic                    wsel_wbrk;

  always_comb begin
    wsel_wbrk  = 1'b0;
    wsel_range = '0;
    if (i_use_index) begin
      wsel_wbrk     = i_object_index == apd_pkg::OBJ_WBRK;
      wsel_range[0] = i_object_index == apd_pkg::OBJ_RANGE_CH0;
      wsel_range[1] = i_object_index == apd_pkg::OBJ_RANGE_CH1;
    end else begin
      wsel_wbrk     = i_record_set_number == apd_pkg::SET_PARAM &&
                      i_byte_offset == apd_pkg::OFS_WBRK;
      wsel_range[0] = i_record_set_number == apd_pkg::SET_RANGE_CH0;
      wsel_range[1] = i_record_set_number == apd_pkg::SET_RANGE_CH1;
    end
  end

  // Reserved bits 7..2 are not stored; reads of set 00 return the diagnostic record instead
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wire_break_enable_r <= apd_pkg::WBRK_RST[1:0];
    end else if (i_rec_wr && wsel_wbrk) begin
      wire_break_enable_r <= i_wdata[1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      channel_range_select_r <= {NUM_CH{apd_pkg::RANGE_RST}};
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (i_rec_wr && wsel_range[c]) begin
          channel_range_select_r[c] <= i_wdata;
        end
      end
    end
  end

  // Writes to any other set or index are acknowledged but dropped
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_wack <= 1'b0;
    end else begin
      o_wack <= i_rec_wr;
    end
  end

  // ----------------------------------------------------------------
  // Wire-break pin synchroniser
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] wbrk_meta_r;
  logic [NUM_CH-1:0] wbrk_sync_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wbrk_meta_r <= '0;
      wbrk_sync_r <= '0;
    end else begin
      wbrk_meta_r <= i_wire_break_pin;
      wbrk_sync_r <= wbrk_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel scaling and fault detection
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] cfg_err;
  logic [NUM_CH-1:0] wbrk_err;
  logic [NUM_CH-1:0] active_nxt;
  logic [NUM_CH-1:0][14:0] current_nxt;

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      logic signed [31:0] code;
      logic signed [31:0] lim_code;
      logic signed [31:0] lo;
      logic signed [31:0] hi;
      logic signed [31:0] ua;
      logic               known;

      always_comb begin
        code  = 32'(signed'(i_out_code[gc]));
        known = 1'b1;
        lo    = 32'sd0;
        hi    = 32'sd0;
        unique case (channel_range_select_r[gc])
          apd_pkg::RNG_WIDE_0_20: begin
            hi = apd_pkg::WIDE_OVER;
          end
          apd_pkg::RNG_BIN_0_20: begin
            hi = apd_pkg::BIN_OVER;
          end
          apd_pkg::RNG_WIDE_4_20: begin
            lo = apd_pkg::WIDE_UNDER;
            hi = apd_pkg::WIDE_OVER;
          end
          apd_pkg::RNG_BIN_4_20: begin
            lo = apd_pkg::BIN_UNDER;
            hi = apd_pkg::BIN_OVER;
          end
          default: begin
            known = 1'b0;
          end
        endcase
        if (code < lo) begin
          lim_code = lo;
        end else if (code > hi) begin
          lim_code = hi;
        end else begin
          lim_code = code;
        end
        unique case (channel_range_select_r[gc])
          apd_pkg::RNG_WIDE_0_20: begin
            ua = lim_code * apd_pkg::SPAN_0_20_UA / apd_pkg::WIDE_FULL;
          end
          apd_pkg::RNG_BIN_0_20: begin
            ua = lim_code * apd_pkg::SPAN_0_20_UA / apd_pkg::BIN_FULL;
          end
          apd_pkg::RNG_WIDE_4_20: begin
            ua = apd_pkg::LIVE_ZERO_UA +
                 lim_code * apd_pkg::SPAN_4_20_UA / apd_pkg::WIDE_FULL;
          end
          apd_pkg::RNG_BIN_4_20: begin
            ua = apd_pkg::LIVE_ZERO_UA +
                 lim_code * apd_pkg::SPAN_4_20_UA / apd_pkg::BIN_FULL;
          end
          default: begin
            ua = 32'sd0;
          end
        endcase
        // Truncation toward zero keeps the live-zero ranges at or above zero
        // microamps, the floor code giving exactly zero; the stage cannot sink current
        if (ua < 0) begin
          ua = 32'sd0;
        end
      end

      // Off and unknown codes both leave the output unpowered
      assign active_nxt[gc]  = known;
      assign current_nxt[gc] = known ? ua[14:0] : 15'h0000;
      assign cfg_err[gc]     = !known &&
        channel_range_select_r[gc] != apd_pkg::RNG_OFF;
      // A switched-off channel has no loop to break
      assign wbrk_err[gc]    = wire_break_enable_r[gc] && known &&
                               wbrk_sync_r[gc];
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_chan_active <= '0;
      o_current_ua  <= '0;
    end else begin
      o_chan_active <= active_nxt;
      o_current_ua  <= current_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Microsecond ticker
  // ----------------------------------------------------------------
  localparam int PRE_W = $clog2(apd_pkg::TICK_CYC);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(apd_pkg::TICK_CYC - 1);

  logic [PRE_W-1:0] pre_cnt_r;
  logic             us_tick;
  logic [31:0]      us_ticker_r;

  assign us_tick = pre_cnt_r == PRE_LAST;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || us_tick) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 1'b1;
    end
  end

  // Wraps after 2^32-1 by natural overflow
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      us_ticker_r <= 32'h0000_0000;
    end else if (us_tick) begin
      us_ticker_r <= us_ticker_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic state
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0][7:0] chan_fault_nxt;
  logic [NUM_CH-1:0][7:0] chan_fault_r;
  logic [7:0]             group_fault_r;
  logic [7:0]             summary_r;
  logic [7:0]             summary_nxt;
  logic [31:0]            diag_timestamp_r;
  logic                   new_fault;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      chan_fault_nxt[c] = 8'h00;
      chan_fault_nxt[c][apd_pkg::CH_CFG_BIT]  = cfg_err[c];
      chan_fault_nxt[c][apd_pkg::CH_WBRK_BIT] = wbrk_err[c];
    end
    summary_nxt = 8'h00;
    summary_nxt[apd_pkg::SUM_EXT_BIT]   = |wbrk_err;
    summary_nxt[apd_pkg::SUM_CHAN_BIT]  = |(cfg_err | wbrk_err);
    summary_nxt[apd_pkg::SUM_PARAM_BIT] = |cfg_err;
  end

  // Any fault bit appearing marks a diagnostic event
  always_comb begin
    new_fault = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      new_fault = new_fault | |(chan_fault_nxt[c] & ~chan_fault_r[c]);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      chan_fault_r  <= '0;
      group_fault_r <= 8'h00;
      summary_r     <= 8'h00;
    end else begin
      chan_fault_r  <= chan_fault_nxt;
      summary_r     <= summary_nxt;
      for (int c = 0; c < NUM_CH; c++) begin
        group_fault_r[c] <= |chan_fault_nxt[c];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      diag_timestamp_r <= 32'h0000_0000;
    end else if (new_fault) begin
      diag_timestamp_r <= us_ticker_r;
    end
  end

  // No interrupt output exists; indicators only
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_chan_err_led  <= '0;
      o_group_err_led <= 1'b0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        o_chan_err_led[c] <= |chan_fault_nxt[c];
      end
      o_group_err_led <= |summary_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic record image
  // ----------------------------------------------------------------
  logic [7:0] diag_byte [20];

  always_comb begin
    for (int b = 0; b < 20; b++) begin
      diag_byte[b] = 8'h00;
    end
    diag_byte[0]  = summary_r;
    diag_byte[1]  = apd_pkg::MODULE_CLASS;
    diag_byte[3]  = 8'h00;
    diag_byte[4]  = apd_pkg::CHANNEL_KIND;
    diag_byte[5]  = apd_pkg::DIAG_BITS;
    diag_byte[6]  = apd_pkg::CHANNEL_COUNT;
    diag_byte[7]  = group_fault_r;
    diag_byte[8]  = chan_fault_r[0];
    diag_byte[9]  = chan_fault_r[1];
    diag_byte[16] = diag_timestamp_r[7:0];
    diag_byte[17] = diag_timestamp_r[15:8];
    diag_byte[18] = diag_timestamp_r[23:16];
    diag_byte[19] = diag_timestamp_r[31:24];
  end

  // ----------------------------------------------------------------
  // Record read decode
  // ----------------------------------------------------------------
  logic [4:0] rd_idx;
  logic [4:0] rd_limit;
  logic       rd_hit;
  logic [7:0] sub_rel;

  always_comb begin
    rd_idx   = i_byte_offset;
    rd_limit = 5'h00;
    rd_hit   = 1'b0;
    sub_rel  = i_object_subindex - apd_pkg::SUB_DIAG_FIRST;
    if (i_use_index) begin
      if (i_object_index == apd_pkg::OBJ_DIAG_FULL) begin
        rd_hit   = 1'b1;
        rd_limit = apd_pkg::DIAG_LEN;
      end else if (i_object_index == apd_pkg::OBJ_DIAG_SHORT) begin
        rd_hit   = 1'b1;
        rd_limit = apd_pkg::DIAG_SHORT_LEN;
      end else if (i_object_index == apd_pkg::OBJ_DIAG_ALT &&
                   i_object_subindex >= apd_pkg::SUB_DIAG_FIRST &&
                   sub_rel < 8'(apd_pkg::DIAG_LEN)) begin
        rd_hit   = 1'b1;
        rd_limit = apd_pkg::DIAG_LEN;
        rd_idx   = sub_rel[4:0];
      end
    end else begin
      if (i_record_set_number == apd_pkg::SET_DIAG_FULL) begin
        rd_hit   = 1'b1;
        rd_limit = apd_pkg::DIAG_LEN;
      end else if (i_record_set_number == apd_pkg::SET_DIAG_SHORT) begin
        rd_hit   = 1'b1;
        rd_limit = apd_pkg::DIAG_SHORT_LEN;
      end
    end
    rd_hit = rd_hit && rd_idx < rd_limit;
  end

  // One-cycle read latency; misses return zero with the error flag
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
      o_rerr   <= 1'b0;
    end else begin
      o_rvalid <= i_rec_rd;
      o_rerr   <= i_rec_rd && !rd_hit;
      if (i_rec_rd) begin
        o_rdata <= rd_hit ? diag_byte[rd_idx] : 8'h00;
      end
    end
  end

endmodule

/* File: core/apd_pkg.sv */
// Constants for the parameter and diagnostic record block
package apd_pkg;

  // ----------------------------------------------------------------
  // Record and object addressing
  // ----------------------------------------------------------------
  localparam logic [7:0]  SET_PARAM      = 8'h00;
  localparam logic [7:0]  SET_RANGE_CH0  = 8'h80;
  localparam logic [7:0]  SET_RANGE_CH1  = 8'h81;
  localparam logic [7:0]  SET_DIAG_FULL  = 8'h01;
  localparam logic [7:0]  SET_DIAG_SHORT = 8'h00;
  localparam logic [15:0] OBJ_WBRK       = 16'h3101;
  localparam logic [15:0] OBJ_RANGE_CH0  = 16'h3102;
  localparam logic [15:0] OBJ_RANGE_CH1  = 16'h3103;
  localparam logic [15:0] OBJ_DIAG_FULL  = 16'h2f01;
  localparam logic [15:0] OBJ_DIAG_SHORT = 16'h2f00;
  localparam logic [15:0] OBJ_DIAG_ALT   = 16'h5005;
  localparam logic [7:0]  SUB_DIAG_FIRST = 8'h02;
  localparam logic [4:0]  OFS_WBRK       = 5'h01;
  localparam logic [4:0]  DIAG_LEN       = 5'h14;
  localparam logic [4:0]  DIAG_SHORT_LEN = 5'h04;
  localparam logic [4:0]  OFS_STAMP      = 5'h10;

  // ----------------------------------------------------------------
  // Reset values and fixed descriptor bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] WBRK_RST      = 8'h00;
  localparam logic [7:0] RANGE_RST     = 8'h31;
  localparam logic [7:0] MODULE_CLASS  = 8'h15;
  localparam logic [7:0] CHANNEL_KIND  = 8'h73;
  localparam logic [7:0] DIAG_BITS     = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT = 8'h02;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SUM_EXT_BIT   = 2;
  localparam int SUM_CHAN_BIT  = 3;
  localparam int SUM_PARAM_BIT = 7;
  localparam int CH_CFG_BIT    = 0;
  localparam int CH_WBRK_BIT   = 4;

  // ----------------------------------------------------------------
  // Range codes and scaling
  // ----------------------------------------------------------------
  localparam logic [7:0] RNG_WIDE_0_20 = 8'h31;
  localparam logic [7:0] RNG_BIN_0_20  = 8'h41;
  localparam logic [7:0] RNG_WIDE_4_20 = 8'h30;
  localparam logic [7:0] RNG_BIN_4_20  = 8'h40;
  localparam logic [7:0] RNG_OFF       = 8'hff;
  localparam int WIDE_FULL  = 27648;
  localparam int BIN_FULL   = 16384;
  localparam int WIDE_OVER  = 32511;
  localparam int BIN_OVER   = 20480;
  localparam int WIDE_UNDER = -6912;
  localparam int BIN_UNDER  = -4096;
  localparam int SPAN_0_20_UA = 20000;
  localparam int SPAN_4_20_UA = 16000;
  localparam int LIVE_ZERO_UA = 4000;

  // ----------------------------------------------------------------
  // Microsecond ticker
  // ----------------------------------------------------------------
  localparam int CLK_MHZ  = 125;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;

endpackage

/* File: testbench/apd_diag_record_sva.sv */
// Port checker for the parameter and diagnostic record block
`timescale 1ns/10ps
module apd_diag_record_sva #(
  parameter int NUM_CH = 2
) (
  input wire logic                    i_ref_clk,
  input wire logic                    i_srst,
  input wire logic                    i_rec_wr,
  input wire logic                    i_rec_rd,
  input wire logic                    i_use_index,
  input wire logic [7:0]              i_record_set_number,
  input wire logic [15:0]             i_object_index,
  input wire logic [7:0]              i_object_subindex,
  input wire logic [4:0]              i_byte_offset,
  input wire logic [7:0]              i_wdata,
  input wire logic [NUM_CH-1:0][15:0] i_out_code,
  input wire logic [NUM_CH-1:0]       i_wire_break_pin,
  input wire logic [7:0]              o_rdata,
  input wire logic                    o_rvalid,
  input wire logic                    o_rerr,
  input wire logic                    o_wack,
  input wire logic [NUM_CH-1:0]       o_chan_active,
  input wire logic [NUM_CH-1:0][14:0] o_current_ua,
  input wire logic [NUM_CH-1:0]       o_chan_err_led,
  input wire logic                    o_group_err_led
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  wire set_rd = i_rec_rd && !i_use_index;
  wire idx_rd = i_rec_rd && i_use_index;

  a_read_answer: assert property (i_rec_rd |=> o_rvalid)
    else $error("read without answer");
  a_no_stray: assert property (o_rvalid |-> $past(i_rec_rd))
    else $error("answer without read");
  a_write_ack: assert property (i_rec_wr |=> o_wack)
    else $error("write not acknowledged");
  a_miss_zero: assert property (o_rerr |-> o_rvalid && o_rdata == 8'h00)
    else $error("miss with data");
  a_bad_set: assert property (set_rd &&
    !(i_record_set_number inside {8'h00, 8'h01}) |=> o_rerr)
    else $error("unknown set answered");
  a_short_len: assert property (set_rd &&
    i_record_set_number == 8'h00 && i_byte_offset >= 5'h04 |=> o_rerr)
    else $error("short record too long");
  a_bad_index: assert property (idx_rd &&
    !(i_object_index inside {16'h2f00, 16'h2f01, 16'h5005}) |=> o_rerr)
    else $error("unknown index answered");
  a_kind_byte: assert property (set_rd &&
    i_record_set_number == 8'h01 && i_byte_offset == 5'h04
    |=> o_rdata == 8'h73 && !o_rerr)
    else $error("channel kind byte wrong");
  a_class_alt: assert property (idx_rd &&
    i_object_index == 16'h5005 && i_object_subindex == 8'h03
    |=> o_rdata == 8'h15)
    else $error("module class byte wrong");
  a_off_zero: assert property (!o_chan_active[0] |->
    o_current_ua[0] == 15'h0000)
    else $error("inactive channel drives");
  a_over_cap: assert property (o_current_ua[0] <= 15'h61a8)
    else $error("current above range");
  a_group_led: assert property (o_group_err_led == |o_chan_err_led)
    else $error("group indicator mismatch");

  c_read_miss: cover property (o_rerr);
  c_chan_off: cover property (!o_chan_active[0] && !o_chan_err_led[0]);
  c_fault_led: cover property (o_chan_err_led[0] ##1 o_chan_err_led[0]);
endmodule

bind apd_diag_record apd_diag_record_sva #(.NUM_CH(NUM_CH)) i_sva (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_rec_wr(i_rec_wr),
  .i_rec_rd(i_rec_rd), .i_use_index(i_use_index),
  .i_record_set_number(i_record_set_number),
  .i_object_index(i_object_index), .i_object_subindex(i_object_subindex),
  .i_byte_offset(i_byte_offset), .i_wdata(i_wdata),
  .i_out_code(i_out_code), .i_wire_break_pin(i_wire_break_pin),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_rerr(o_rerr),
  .o_wack(o_wack), .o_chan_active(o_chan_active),
  .o_current_ua(o_current_ua), .o_chan_err_led(o_chan_err_led),
  .o_group_err_led(o_group_err_led));

/* File: testbench/apd_host_model.sv */
// Head station model issuing record reads and writes
`timescale 1ns/10ps
module apd_host_model (
  input  wire logic        i_ref_clk,
  output logic             o_rec_wr,
  output logic             o_rec_rd,
  output logic             o_use_index,
  output logic [7:0]       o_set,
  output logic [15:0]      o_index,
  output logic [7:0]       o_sub,
  output logic [4:0]       o_ofs,
  output logic [7:0]       o_wdata
);
  initial begin
    o_rec_wr = 1'b0;
    o_rec_rd = 1'b0;
    o_use_index = 1'b0;
    o_set = 8'h00;
    o_index = 16'h0000;
    o_sub = 8'h00;
    o_ofs = 5'h00;
    o_wdata = 8'h00;
  end

  // One byte per edge; callers chain calls for back-to-back traffic
  task automatic access(input logic wr, input logic idx,
                        input logic [7:0] s, input logic [15:0] x,
                        input logic [7:0] sb, input logic [4:0] o,
                        input logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_rec_wr = wr;
    o_rec_rd = !wr;
    o_use_index = idx;
    o_set = s;
    o_index = x;
    o_sub = sb;
    o_ofs = o;
    o_wdata = d;
  endtask

  // Released lines flip so a stale address never looks valid
  task automatic release_bus();
    @(posedge i_ref_clk);
    #1;
    o_rec_wr = 1'b0;
    o_rec_rd = 1'b0;
    o_set = ~o_set;
    o_index = ~o_index;
    o_sub = ~o_sub;
    o_ofs = ~o_ofs;
    o_wdata = ~o_wdata;
  endtask
endmodule

/* File: testbench/aout_param_diag_record_tb_top.sv */
// Self-checking bench for the parameter and diagnostic record block
`timescale 1ns/10ps
module aout_param_diag_record_tb_top;
  logic              i_ref_clk = 1'b0;
  logic              i_srst    = 1'b1;
  logic              rec_wr, rec_rd, use_idx, rvalid, rerr, wack, gled;
  logic [7:0]        set_n, osub, wd, rdata;
  logic [15:0]       oidx;
  logic [4:0]        ofs;
  logic [1:0][15:0]  code = '0;
  logic [1:0]        wpin = 2'b00;
  logic [1:0]        act, cled;
  logic [1:0][14:0]  ua;
  logic [8:0]        exp_q[$];
  logic [31:0]       seed = 32'h00008a46;
  logic [7:0]        rcodes [4] = '{8'h31, 8'h41, 8'h30, 8'h40};
  logic [7:0]        dflt [20] = '{1: 8'h15, 4: 8'h73, 5: 8'h08,
                                   6: 8'h02, default: 8'h00};
  logic [15:0]       edge_v [12] = '{16'h0000, 16'h4000, 16'h5000,
    16'h5001, 16'h6c00, 16'h7eff, 16'h7fff, 16'hffff, 16'hf000,
    16'hefff, 16'he500, 16'h8000};
  int                num_errors = 0;
  int                n_compared = 0;
  int                v;
  int                cyc_n = 0;

  always #4 i_ref_clk = ~i_ref_clk;

  apd_diag_record #(.NUM_CH(2)) i_dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_rec_wr(rec_wr),
    .i_rec_rd(rec_rd), .i_use_index(use_idx), .i_record_set_number(set_n),
    .i_object_index(oidx), .i_object_subindex(osub), .i_byte_offset(ofs),
    .i_wdata(wd), .i_out_code(code), .i_wire_break_pin(wpin),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_rerr(rerr), .o_wack(wack),
    .o_chan_active(act), .o_current_ua(ua), .o_chan_err_led(cled),
    .o_group_err_led(gled));

  apd_host_model i_host (
    .i_ref_clk(i_ref_clk), .o_rec_wr(rec_wr), .o_rec_rd(rec_rd),
    .o_use_index(use_idx), .o_set(set_n), .o_index(oidx), .o_sub(osub),
    .o_ofs(ofs), .o_wdata(wd));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [14:0] exp_ua(input logic [7:0] r, input int c);
    int lo, hi, full, span, base;
    lo = r == apd_pkg::RNG_WIDE_4_20 ? apd_pkg::WIDE_UNDER :
         (r == apd_pkg::RNG_BIN_4_20 ? apd_pkg::BIN_UNDER : 0);
    hi = r[6] ? apd_pkg::BIN_OVER : apd_pkg::WIDE_OVER;
    full = r[6] ? apd_pkg::BIN_FULL : apd_pkg::WIDE_FULL;
    base = r[0] ? 0 : apd_pkg::LIVE_ZERO_UA;
    span = r[0] ? apd_pkg::SPAN_0_20_UA : apd_pkg::SPAN_4_20_UA;
    c = c < lo ? lo : (c > hi ? hi : c);
    return 15'(base + c * span / full);
  endfunction

  task automatic cmp_rd(input string w, input logic [8:0] e,
                        input logic [8:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", w, e, s);
    end
  endtask

  task automatic cmp_lv(input string w, input logic [14:0] e,
                        input logic [14:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", w, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // Set number doubles as subindex when addressing by index
  task automatic rd(input logic i, input logic [7:0] s,
                    input logic [15:0] x, input logic [4:0] o,
                    input logic [8:0] e);
    exp_q.push_back(e);
    i_host.access(1'b0, i, s, x, s, o, 8'h00);
  endtask

  task automatic wr(input logic [7:0] s, input logic [4:0] o,
                    input logic [7:0] d);
    i_host.access(1'b1, 1'b0, s, 16'h0000, 8'h00, o, d);
    i_host.release_bus();
    cyc(2);
  endtask

  task automatic wrx(input logic [15:0] x, input logic [7:0] d);
    i_host.access(1'b1, 1'b1, 8'h00, x, 8'h00, 5'h00, d);
    i_host.release_bus();
    cyc(2);
  endtask

  task automatic report_and_stop();
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("BAD read queue exp 0 got %0d", exp_q.size());
    end
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Edges since reset left, the same count the microsecond ticker sees
  always @(posedge i_ref_clk) begin
    cyc_n <= i_srst ? 0 : cyc_n + 1;
  end

  always @(negedge i_ref_clk) begin
    if (rvalid === 1'b1) begin
      cmp_rd("read", exp_q.size() ? exp_q.pop_front() : 9'h1ff,
             {rerr, rdata});
    end
  end

  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    cyc(2);
    i_srst = 1'b0;
    for (int k = 0; k < 20; k++) begin
      rd(1'b0, 8'h01, 16'h0000, k[4:0], {1'b0, dflt[k]});
    end
    rd(1'b0, 8'h00, 16'h0000, 5'h01, 9'h015);
    rd(1'b0, 8'h00, 16'h0000, 5'h04, 9'h100);
    rd(1'b0, 8'h02, 16'h0000, 5'h00, 9'h100);
    rd(1'b0, 8'h01, 16'h0000, 5'h14, 9'h100);
    rd(1'b1, 8'h00, 16'h2f00, 5'h04, 9'h100);
    rd(1'b1, 8'h00, 16'h2f01, 5'h06, 9'h002);
    rd(1'b1, 8'h03, 16'h5005, 5'h00, 9'h015);
    rd(1'b1, 8'h16, 16'h5005, 5'h00, 9'h100);
    rd(1'b1, 8'h00, 16'h1234, 5'h00, 9'h100);
    i_host.release_bus();
    foreach (rcodes[j]) begin
      wr(8'h80, 5'h00, rcodes[j]);
      for (int k = 0; k < 24; k++) begin
        v = k < 12 ? int'($signed(edge_v[k])) : int'($signed(seed[15:0]));
        seed = xs(seed);
        code = {v[15:0], v[15:0]};
        cyc(2);
        cmp_lv("current0", exp_ua(rcodes[j], v), ua[0]);
        cmp_lv("current1", exp_ua(8'h31, v), ua[1]);
        cmp_lv("active", 15'h0003, {13'h0, act});
      end
    end
    wr(8'h80, 5'h00, 8'hff);
    cmp_lv("off current", 15'h0000, ua[0]);
    cmp_lv("active", 15'h0002, {13'h0, act});
    cmp_lv("led", 15'h0000, {13'h0, cled});
    wr(8'h80, 5'h00, 8'h55);
    cmp_lv("led", 15'h0001, {13'h0, cled});
    cmp_lv("group led", 15'h0001, {14'h0, gled});
    // Fault rose at the write edge, two edges before this point
    v = (cyc_n - 2) / apd_pkg::TICK_CYC;
    rd(1'b0, 8'h01, 16'h0000, 5'h10, {1'b0, v[7:0]});
    rd(1'b0, 8'h01, 16'h0000, 5'h00, 9'h088);
    rd(1'b0, 8'h01, 16'h0000, 5'h07, 9'h001);
    rd(1'b0, 8'h01, 16'h0000, 5'h08, 9'h001);
    i_host.release_bus();
    wr(8'h81, 5'h00, 8'hff);
    cmp_lv("active", 15'h0000, {13'h0, act});
    wrx(16'h3103, 8'h31);
    cmp_lv("active", 15'h0002, {13'h0, act});
    wrx(16'h3102, 8'h31);
    cmp_lv("active", 15'h0003, {13'h0, act});
    wpin = 2'b11;
    cyc(4);
    cmp_lv("led", 15'h0000, {13'h0, cled});
    wr(8'h00, 5'h01, 8'hfd);
    cyc(4);
    cmp_lv("led", 15'h0001, {13'h0, cled});
    rd(1'b0, 8'h01, 16'h0000, 5'h08, 9'h010);
    rd(1'b0, 8'h01, 16'h0000, 5'h09, 9'h000);
    rd(1'b0, 8'h01, 16'h0000, 5'h00, 9'h00c);
    i_host.release_bus();
    wrx(16'h3101, 8'h02);
    cyc(4);
    cmp_lv("led", 15'h0002, {13'h0, cled});
    i_srst = 1'b1;
    cyc(2);
    i_srst = 1'b0;
    cyc(4);
    cmp_lv("led", 15'h0000, {13'h0, cled});
    rd(1'b0, 8'h01, 16'h0000, 5'h10, 9'h000);
    i_host.release_bus();
    cyc(3);
    report_and_stop();
  end
endmodule
